// ---- inc/anlink_pkg.sv ----
// Purpose: shared constants for the link-control block
// Assumes: 200 MHz system clock
// Notes: times are kept in their own unit, cycle counts derived
package anlink_pkg;
  localparam int unsigned CLK_MHZ = 200;
  // Jabber cut-off, longest time, in ms
  localparam int unsigned JAB_MS = 45;
  localparam longint unsigned JAB_CYC = longint'(JAB_MS) * 1000 * CLK_MHZ;
  // Break-link wait, in ms
  localparam int unsigned BRK_MS = 1200;
  localparam longint unsigned BRK_CYC = longint'(BRK_MS) * 1000 * CLK_MHZ;
  // Link code word layout
  localparam int unsigned LCW_W = 16;
  localparam int unsigned SEL_W = 5;
  localparam logic [4:0] SEL_8023 = 5'h01;
  localparam int unsigned ABL_LO = 5;
  localparam int unsigned ABL_HI = 8;
  localparam int unsigned ACK_BIT = 14;
  // Ability bits inside [8:5]
  localparam int unsigned AB_10H = 0;
  localparam int unsigned AB_10F = 1;
  localparam int unsigned AB_100H = 2;
  localparam int unsigned AB_100F = 3;
  // Burst layout
  localparam int unsigned BURST_PULSES = 33;
  localparam int unsigned FRAME_PULSES = 17;
  localparam int unsigned DATA_PULSES = 16;
  // Consecutive matching words before acknowledge
  localparam int unsigned MATCH_CNT = 3;
  // Reset values
  localparam logic [3:0] ABL_RST = 4'h0;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_BREAK = 6'h02,
    ST_ABIL  = 6'h04,
    ST_ACK   = 6'h08,
    ST_LINK  = 6'h10,
    ST_FORCE = 6'h20
  } an_state_e;
endpackage

// ---- rtl/jabber_guard.sv ----
// Purpose: transmit jabber watchdog
// Assumes: i_tx_en synchronous to i_clk_sys
// Notes: sticky flag cleared by the caller pulse
`timescale 1ns/1ps
module jabber_guard #(
  parameter longint unsigned LIMIT = anlink_pkg::JAB_CYC
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Transmit side
  input wire logic i_tx_en,
  input wire logic i_flag_clr,
  output logic o_cut,
  output logic o_flag
);
  import anlink_pkg::*;
  initial begin
    if (LIMIT < 2) $error("jabber limit too small");
  end
  logic [39:0] cnt_q, cnt_d;
  logic cut_q, cut_d, flag_q, flag_d;
  localparam logic [39:0] LIM = 40'(LIMIT - 1);

  // Count while enabled; cut at limit, release on drop
  always_comb begin
    cnt_d = cnt_q;
    cut_d = cut_q;
    flag_d = flag_q;
    if (!i_tx_en) begin
      cnt_d = '0;
      cut_d = 1'b0;
    end else if (cnt_q >= LIM) begin
      cut_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 40'h1;
    end
    if (i_flag_clr) flag_d = 1'b0;
    if (cut_d) flag_d = 1'b1; // Set beats clear
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= '0;
      cut_q <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      cut_q <= cut_d;
      flag_q <= flag_d;
    end
  end
  assign o_cut = cut_q;
  assign o_flag = flag_q;

  a_jab_release: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !i_tx_en |=> !cut_q) else $error("jabber not released");
  a_jab_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $rose(cut_q) |-> flag_q) else $error("jabber flag missing");
endmodule // jabber_guard

// ---- rtl/autoneg_jabber_link_control.sv ----
// Purpose: auto-negotiation and jabber control for a 10/100 transceiver
// Assumes: pulse detection and burst framing done by the analog side
// Notes: burst words arrive as whole 16-bit words with a valid strobe
//
// Contract
// - Cut transmission within 45 ms of continuous transmit enable.
// - Clear jabber once transmit enable drops.
// - Sticky jabber-detected status bit for software.
// - Start negotiation on resets, link loss or restart bit.
// - Burst has 17 framing pulses and 16 data pulses.
// - First five word bits are the 802.3 selector.
// - Abilities come from advertisement bits 8 to 5, software writable.
// - Advertisement write alone does not restart negotiation.
// - Resolve 100F, 100H, 10F, 10H in that order.
// - After match, keep sending words with acknowledge set.
// - Restart if received word changes or bursts go missing.
// - Initial abilities and enable come from straps at reset release.
// - No next page; only base word exchanged.
// - Without fast pulses, take speed from line, assume half duplex.
// - Parallel-detected link clears partner-negotiable bit.
// - Fault in parallel detection sets fault status bit.
// - Partner ability holds received word, or detected speed.
// - Software restart stops traffic, waits 1200 ms, then restarts.
// - Loss of received signal restarts negotiation.
// - Negotiation disabled forces speed and duplex from control bits.
// - Half duplex: carrier from tx or rx, rx during tx collides.
// - Full duplex: carrier from rx only, no collision.
`timescale 1ns/1ps
module autoneg_jabber_link_control #(
  parameter longint unsigned JAB_LIMIT = anlink_pkg::JAB_CYC,
  parameter longint unsigned BRK_LIMIT = anlink_pkg::BRK_CYC,
  parameter int unsigned MISS_LIMIT = 4096
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Straps, sampled at reset release
  input wire logic [3:0] i_strap_abil,
  input wire logic i_strap_an_en,
  // Control bits
  input wire logic i_sw_reset,
  input wire logic i_pd_reset,
  input wire logic i_an_restart,
  input wire logic i_an_en_wr,
  input wire logic i_an_en_val,
  input wire logic i_adv_wr,
  input wire logic [3:0] i_adv_val,
  input wire logic i_force_100,
  input wire logic i_force_fdx,
  input wire logic i_jab_clr,
  input wire logic i_pdf_clr,
  // Line side
  input wire logic i_rx_word_vld,
  input wire logic [anlink_pkg::LCW_W-1:0] i_rx_word,
  input wire logic i_det_100,
  input wire logic i_det_nlp,
  input wire logic i_sig_ok,
  input wire logic i_tx_en,
  input wire logic i_rx_act,
  // Outputs to line
  output logic o_tx_word_vld,
  output logic [anlink_pkg::LCW_W-1:0] o_tx_word,
  output logic [anlink_pkg::BURST_PULSES-1:0] o_tx_pulses,
  output logic o_tx_gate,
  output logic o_traffic_off,
  // Status
  output logic o_crs,
  output logic o_col,
  output logic o_jab_det,
  output logic o_an_done,
  output logic o_link_up,
  output logic o_spd_100,
  output logic o_fdx,
  output logic o_an_en,
  output logic [3:0] o_adv,
  output logic [anlink_pkg::LCW_W-1:0] o_lp_abil,
  output logic o_lp_an_able,
  output logic o_pd_fault
);
  import anlink_pkg::*;
  initial begin
    if (MISS_LIMIT < 2 || BRK_LIMIT < 2) $error("limits too small");
  end

  logic jab_cut, jab_flag;
  jabber_guard #(.LIMIT(JAB_LIMIT)) u_jab (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_tx_en(i_tx_en),
    .i_flag_clr(i_jab_clr),
    .o_cut(jab_cut),
    .o_flag(jab_flag)
  );

  an_state_e st_q, st_d;
  logic [40:0] tmr_q, tmr_d;
  logic [3:0] adv_q, adv_d, adv_act_q, adv_act_d;
  logic an_en_q, an_en_d, strap_q, strap_d;
  logic [LCW_W-1:0] lp_q, lp_d;
  logic [1:0] mcnt_q, mcnt_d;
  logic lp_able_q, lp_able_d, pdf_q, pdf_d;
  logic done_q, done_d, up_q, up_d, s100_q, s100_d, fdx_q, fdx_d;
  logic crs_q, crs_d, col_q, col_d, gate_q, gate_d;
  logic [3:0] common;
  logic restart_ev, sw_brk;
  localparam logic [40:0] BRK_L = 41'(BRK_LIMIT - 1);
  localparam logic [40:0] MISS_L = 41'(MISS_LIMIT - 1);

  // Word we send: selector, abilities, ack (no next page bit)
  function automatic logic [LCW_W-1:0] mk_word(input logic [3:0] ab,
                                               input logic ack);
    logic [LCW_W-1:0] w;
    w = '0;
    w[SEL_W-1:0] = SEL_8023;
    w[ABL_HI:ABL_LO] = ab;
    w[ACK_BIT] = ack;
    return w; // Bit 15 kept zero
  endfunction

  // Spread a word onto 33 pulse slots, framing on even indices
  function automatic logic [BURST_PULSES-1:0] mk_burst(
      input logic [LCW_W-1:0] w);
    logic [BURST_PULSES-1:0] b;
    b = '0;
    for (int i = 0; i < FRAME_PULSES; i++) b[2*i] = 1'b1;
    for (int i = 0; i < DATA_PULSES; i++) b[2*i+1] = w[i];
    return b;
  endfunction

  // Both sides' abilities ANDed
  assign common = adv_act_q & i_rx_word[ABL_HI:ABL_LO];
  assign restart_ev = i_sw_reset || i_pd_reset;
  assign sw_brk = i_an_restart;

  // Negotiation state and status
  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q + 41'h1;
    adv_d = adv_q;
    adv_act_d = adv_act_q;
    an_en_d = an_en_q;
    strap_d = 1'b0;
    lp_d = lp_q;
    mcnt_d = mcnt_q;
    lp_able_d = lp_able_q;
    pdf_d = pdf_q;
    done_d = done_q;
    up_d = up_q;
    s100_d = s100_q;
    fdx_d = fdx_q;
    if (i_adv_wr) adv_d = i_adv_val; // No restart here
    if (i_an_en_wr) an_en_d = i_an_en_val;
    if (i_pdf_clr) pdf_d = 1'b0;
    if (strap_q) begin
      adv_d = i_strap_abil;
      an_en_d = i_strap_an_en;
      st_d = ST_IDLE;
    end
    case (st_q)
      ST_IDLE: begin
        tmr_d = '0;
        mcnt_d = '0;
        done_d = 1'b0;
        up_d = 1'b0;
        if (strap_q) begin
          st_d = ST_IDLE; // Enable bit not loaded yet, wait one edge
        end else if (an_en_q) begin
          adv_act_d = adv_q; // Latest advertisement taken here
          st_d = ST_ABIL;
        end else begin
          st_d = ST_FORCE;
        end
      end
      ST_BREAK: begin
        if (tmr_q >= BRK_L) st_d = ST_IDLE;
      end
      ST_ABIL: begin
        if (i_rx_word_vld) begin
          tmr_d = '0;
          lp_d = i_rx_word;
          lp_able_d = 1'b1;
          mcnt_d = (i_rx_word == lp_q) ? mcnt_q + 2'h1 : 2'h0;
          if (mcnt_q == 2'(MATCH_CNT - 1)) st_d = ST_ACK;
        end else if (tmr_q >= MISS_L) begin
          tmr_d = '0;
          if (i_det_100 || i_det_nlp) begin
            if (i_det_100 && i_det_nlp) begin
              pdf_d = 1'b1;
            end else begin
              lp_able_d = 1'b0;
              lp_d = '0;
              lp_d[ABL_LO + (i_det_100 ? AB_100H : AB_10H)] = 1'b1;
              s100_d = i_det_100;
              fdx_d = 1'b0;
              done_d = 1'b1;
              up_d = 1'b1;
              st_d = ST_LINK;
            end
          end
        end
      end
      ST_ACK: begin
        if (i_rx_word_vld) begin
          tmr_d = '0;
          if (i_rx_word[ABL_HI:0] != lp_q[ABL_HI:0]) begin
            st_d = ST_IDLE;
          end else if (i_rx_word[ACK_BIT]) begin
            // Priority resolution
            if (common[AB_100F]) begin
              s100_d = 1'b1;
              fdx_d = 1'b1;
            end else if (common[AB_100H]) begin
              s100_d = 1'b1;
              fdx_d = 1'b0;
            end else if (common[AB_10F]) begin
              s100_d = 1'b0;
              fdx_d = 1'b1;
            end else begin
              s100_d = 1'b0;
              fdx_d = 1'b0;
            end
            lp_d = i_rx_word;
            done_d = |common;
            up_d = |common;
            st_d = (|common) ? ST_LINK : ST_IDLE;
          end
        end else if (tmr_q >= MISS_L) begin
          st_d = ST_IDLE; // Burst missing
        end
      end
      ST_LINK: begin
        tmr_d = '0;
        if (!i_sig_ok) st_d = ST_IDLE;
      end
      ST_FORCE: begin
        tmr_d = '0;
        s100_d = i_force_100;
        fdx_d = i_force_fdx;
        up_d = i_sig_ok;
        done_d = 1'b0;
        if (an_en_q) st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    if (st_q != ST_FORCE && st_q != ST_IDLE && !an_en_q) st_d = ST_IDLE;
    if (restart_ev) st_d = ST_IDLE;
    if (sw_brk && an_en_q) begin
      st_d = ST_BREAK;
      tmr_d = '0;
      done_d = 1'b0;
      up_d = 1'b0;
    end
  end

  // Carrier, collision and transmit gate
  always_comb begin
    gate_d = (st_d == ST_LINK || st_d == ST_FORCE) && !jab_cut;
    if (fdx_d) begin
      crs_d = i_rx_act;
      col_d = 1'b0;
    end else begin
      crs_d = i_rx_act || i_tx_en;
      col_d = i_rx_act && i_tx_en;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= ST_IDLE;
      tmr_q <= '0;
      adv_q <= ABL_RST;
      adv_act_q <= ABL_RST;
      an_en_q <= 1'b0;
      strap_q <= 1'b1; // Straps taken on first edge after release
      lp_q <= '0;
      mcnt_q <= '0;
      lp_able_q <= 1'b0;
      pdf_q <= 1'b0;
      done_q <= 1'b0;
      up_q <= 1'b0;
      s100_q <= 1'b0;
      fdx_q <= 1'b0;
      crs_q <= 1'b0;
      col_q <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      adv_q <= adv_d;
      adv_act_q <= adv_act_d;
      an_en_q <= an_en_d;
      strap_q <= strap_d;
      lp_q <= lp_d;
      mcnt_q <= mcnt_d;
      lp_able_q <= lp_able_d;
      pdf_q <= pdf_d;
      done_q <= done_d;
      up_q <= up_d;
      s100_q <= s100_d;
      fdx_q <= fdx_d;
      crs_q <= crs_d;
      col_q <= col_d;
      gate_q <= gate_d;
    end
  end

  // Output word and burst registers
  logic [LCW_W-1:0] txw_q, txw_d;
  logic [BURST_PULSES-1:0] txp_q;
  logic txv_q, off_q, jabo_q;
  always_comb begin
    txw_d = mk_word(adv_act_q, st_q == ST_ACK);
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      txw_q <= '0;
      txp_q <= '0;
      txv_q <= 1'b0;
      off_q <= 1'b1;
      jabo_q <= 1'b0;
    end else begin
      txw_q <= txw_d;
      txp_q <= mk_burst(txw_d);
      txv_q <= (st_q == ST_ABIL || st_q == ST_ACK);
      off_q <= (st_q == ST_BREAK);
      jabo_q <= jab_flag;
    end
  end

  assign o_tx_word = txw_q;
  assign o_tx_pulses = txp_q;
  assign o_tx_word_vld = txv_q;
  assign o_traffic_off = off_q;
  assign o_tx_gate = gate_q;
  assign o_crs = crs_q;
  assign o_col = col_q;
  assign o_jab_det = jabo_q;
  assign o_an_done = done_q;
  assign o_link_up = up_q;
  assign o_spd_100 = s100_q;
  assign o_fdx = fdx_q;
  assign o_an_en = an_en_q;
  assign o_adv = adv_q;
  assign o_lp_abil = lp_q;
  assign o_lp_an_able = lp_able_q;
  assign o_pd_fault = pdf_q;

  a_fdx_no_col: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    fdx_q |-> !col_q) else $error("collision in full duplex");
  a_hdx_col: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_tx_en && i_rx_act && !fdx_d) |=> col_q)
    else $error("missed collision");
  a_sel_field: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    txv_q |-> txw_q[4:0] == SEL_8023) else $error("bad selector");
  a_burst_frame: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    txv_q |-> (txp_q[0] && txp_q[32] && txp_q[1] == txw_q[0]))
    else $error("bad burst framing");
  a_restart_break: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_an_restart && an_en_q) |=> ##1 off_q)
    else $error("restart did not stop traffic");
  a_sig_loss: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (st_q == ST_LINK && !i_sig_ok && !i_an_restart) |=> st_q == ST_IDLE)
    else $error("link loss ignored");
  a_force_spd: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (st_q == ST_FORCE && $stable(st_q)) |=> s100_q == $past(i_force_100))
    else $error("forced speed wrong");
  a_pd_half: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (done_q && !lp_able_q) |-> !fdx_q)
    else $error("parallel link not half");
  a_ack_bit: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (st_q == ST_ACK) |=> txw_q[ACK_BIT]) else $error("ack missing");
  c_link: cover property (@(posedge i_clk_sys) st_q == ST_LINK && lp_able_q);
  c_pd: cover property (@(posedge i_clk_sys) st_q == ST_LINK && !lp_able_q);
  c_brk: cover property (@(posedge i_clk_sys)
    $past(st_q) == ST_BREAK && st_q == ST_IDLE);
  c_jab: cover property (@(posedge i_clk_sys) $rose(o_jab_det));
endmodule // autoneg_jabber_link_control

// ---- verif/link_partner.sv ----
// Purpose: remote link partner sending link code words
// Assumes: one whole word per burst, bursts PERIOD cycles apart
// Notes: acknowledges only after seeing the local acknowledge
`timescale 1ns/1ps
module link_partner #(
  parameter int unsigned PERIOD = 8
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Bench control
  input wire logic i_on,
  input wire logic [3:0] i_abil,
  // Local device bursts
  input wire logic i_tx_word_vld,
  input wire logic [15:0] i_tx_word,
  // Words toward the device
  output logic o_rx_word_vld,
  output logic [15:0] o_rx_word
);
  import anlink_pkg::*;
  logic [7:0] cnt_q, cnt_d;
  logic ack_q, ack_d;
  logic [15:0] word;
  // Base word only, next page bit kept clear
  assign word = {1'b0, ack_q, 5'h00, i_abil, SEL_8023};
  // Burst spacing and acknowledge tracking
  always_comb begin
    cnt_d = (cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
    ack_d = ack_q;
    if (!i_on) ack_d = 1'b0;
    else if (i_tx_word_vld) ack_d = i_tx_word[ACK_BIT];
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= 8'h00;
      ack_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ack_q <= ack_d;
    end
  end
  // Between bursts a moving pattern, so stale data never looks valid
  assign o_rx_word_vld = i_on && (cnt_q == 8'h00);
  assign o_rx_word = o_rx_word_vld ? word : {cnt_q, ~cnt_q};
endmodule // link_partner

// ---- verif/autoneg_jabber_link_control_bench.sv ----
// Purpose: self-checking bench for the link-control block
// Assumes: jabber, break and burst timeouts shortened by parameter
// Notes: partner model bursts every 8 cycles
`timescale 1ns/1ps
module autoneg_jabber_link_control_bench;
  import anlink_pkg::*;
  localparam int JAB = 50;
  localparam int BRK = 40;
  // Design inputs
  logic i_clk_sys = 1'b0, i_rst_b = 1'b0, i_strap_an_en = 1'b1;
  logic [3:0] i_strap_abil = 4'hF, i_adv_val = 4'h0, p_abil = 4'h1;
  logic i_sw_reset = 0, i_pd_reset = 0, i_an_restart = 0, i_an_en_wr = 0;
  logic i_an_en_val = 0, i_adv_wr = 0, i_force_100 = 0, i_force_fdx = 0;
  logic i_jab_clr = 0, i_pdf_clr = 0, i_det_100 = 0, i_det_nlp = 0;
  logic i_sig_ok = 1, i_tx_en = 0, i_rx_act = 0, p_on = 0;
  logic i_rx_word_vld;
  logic [15:0] i_rx_word, o_tx_word, o_lp_abil;
  // Design outputs
  logic o_tx_word_vld, o_tx_gate, o_traffic_off, o_crs, o_col, o_jab_det;
  logic o_an_done, o_link_up, o_spd_100, o_fdx, o_an_en, o_lp_an_able;
  logic o_pd_fault;
  int n_ack = 0, ack_base = 0;
  logic [32:0] o_tx_pulses;
  logic [3:0] o_adv, cur_adv;
  int err_total = 0, n_checks = 0;

  always #2.5 i_clk_sys = ~i_clk_sys;

  autoneg_jabber_link_control #(.JAB_LIMIT(JAB), .BRK_LIMIT(BRK),
    .MISS_LIMIT(20)) uut (
    .i_clk_sys, .i_rst_b, .i_strap_abil, .i_strap_an_en, .i_sw_reset,
    .i_pd_reset, .i_an_restart, .i_an_en_wr, .i_an_en_val, .i_adv_wr,
    .i_adv_val, .i_force_100, .i_force_fdx, .i_jab_clr, .i_pdf_clr,
    .i_rx_word_vld, .i_rx_word, .i_det_100, .i_det_nlp, .i_sig_ok,
    .i_tx_en, .i_rx_act, .o_tx_word_vld, .o_tx_word, .o_tx_pulses,
    .o_tx_gate, .o_traffic_off, .o_crs, .o_col, .o_jab_det, .o_an_done,
    .o_link_up, .o_spd_100, .o_fdx, .o_an_en, .o_adv, .o_lp_abil,
    .o_lp_an_able, .o_pd_fault);
  link_partner #(.PERIOD(8)) peer (.i_clk_sys, .i_rst_b, .i_on(p_on),
    .i_abil(p_abil), .i_tx_word_vld(o_tx_word_vld), .i_tx_word(o_tx_word),
    .o_rx_word_vld(i_rx_word_vld), .o_rx_word(i_rx_word));

  task automatic chk(input logic [32:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Priority pick of the common abilities, as {100M, full duplex}
  function automatic logic [1:0] resolve(input logic [3:0] c);
    if (c[AB_100F]) return 2'h3;
    if (c[AB_100H]) return 2'h2;
    if (c[AB_10F]) return 2'h1;
    return 2'h0;
  endfunction
  function automatic logic [32:0] burst(input logic [15:0] w);
    logic [32:0] b;
    for (int i = 0; i < 33; i++) b[i] = (i % 2 == 0) ? 1'b1 : w[i / 2];
    return b;
  endfunction
  function automatic logic [3:0] pick(input logic [3:0] o);
    logic [3:0] v;
    do v = 4'($urandom_range(15, 1)); while ((v & o) == 4'h0);
    return v;
  endfunction
  // Bounded wait: 0 done, 1 link, 2 parallel fault
  task automatic wait_st(input int sel);
    int k;
    k = 0;
    while ((sel == 0 ? o_an_done : sel == 1 ? o_link_up : o_pd_fault)
           !== 1'b1 && k < 400) begin
      cyc(1);
      k++;
    end
    if (k >= 400) begin
      err_total++;
      $display("ERROR %0t wait %0d timed out", $time, sel);
    end
  endtask
  task automatic negotiate();
    wait_st(0);
    chk({o_link_up, o_traffic_off, o_an_done}, 3'h5, "done");
    chk({o_spd_100, o_fdx}, resolve(cur_adv & p_abil), "mode");
    chk(o_lp_abil[8:0], {p_abil, SEL_8023}, "lp word");
    chk({o_lp_an_able, n_ack > ack_base}, 2'h3, "ack seen");
    ack_base = n_ack;
  endtask

  // Every burst sent is checked field by field
  always @(negedge i_clk_sys) begin
    if (o_tx_word_vld === 1'b1) begin
      chk(o_tx_word[4:0], SEL_8023, "selector");
      chk(o_tx_word[8:5], cur_adv, "abilities");
      chk(o_tx_word[15], 1'b0, "next page");
      chk(o_tx_pulses, burst(o_tx_word), "pulses");
      if (o_tx_word[ACK_BIT] === 1'b1) n_ack++;
    end
  end

  initial begin
    logic [3:0] d;
    d = 4'($urandom(32'h0cde3316));
    cur_adv = pick(4'hF);
    i_strap_abil <= cur_adv;
    p_abil <= pick(cur_adv);
    p_on <= 1'b1;
    cyc(5);
    chk(o_traffic_off, 1'b1, "in reset");
    @(posedge i_clk_sys) i_rst_b <= 1'b1;
    cyc(2);
    chk({o_an_en, o_adv}, {1'b1, cur_adv}, "straps");
    // Link loss, software reset and pd reset, forced bits randomised but ignored
    for (int i = 0; i < 3; i++) begin
      negotiate();
      @(posedge i_clk_sys) begin
        p_abil <= pick(cur_adv);
        {i_force_100, i_force_fdx} <= 2'($urandom);
        if (i == 0) i_sig_ok <= 1'b0;
        if (i == 1) i_sw_reset <= 1'b1;
        if (i == 2) i_pd_reset <= 1'b1;
      end
      @(posedge i_clk_sys) {i_sig_ok, i_sw_reset, i_pd_reset} <= 3'h4;
      cyc(2);
      chk(o_link_up, 1'b0, "link drop");
    end
    // Partner falls silent mid-acknowledge: no link, back to abilities
    for (int k = 0; k < 200 && o_tx_word[ACK_BIT] !== 1'b1; k++) cyc(1);
    @(posedge i_clk_sys) p_on <= 1'b0;
    cyc(30);
    chk({o_tx_word_vld, o_tx_word[ACK_BIT], o_an_done}, 3'h4,
      "ack miss");
    ack_base = n_ack;
    @(posedge i_clk_sys) p_on <= 1'b1;
    negotiate();
    // Advertisement write alone must leave the link alone
    d = pick(p_abil);
    @(posedge i_clk_sys) {i_adv_wr, i_adv_val} <= {1'b1, d};
    @(posedge i_clk_sys) i_adv_wr <= 1'b0;
    cyc(20);
    chk({o_adv, o_an_done}, {d, 1'b1}, "adv write");
    cur_adv = d;
    @(posedge i_clk_sys) i_an_restart <= 1'b1;
    @(posedge i_clk_sys) i_an_restart <= 1'b0;
    cyc(BRK - 5);
    chk({o_traffic_off, o_an_done}, 2'h2, "break");
    negotiate();
    // Parallel detection: 100M, 10M, then both as a fault
    for (int i = 0; i < 3; i++) begin
      @(posedge i_clk_sys) begin
        p_on <= 1'b0;
        {i_det_100, i_det_nlp} <= (i == 0) ? 2'h2 : (i == 1) ? 2'h1 : 2'h3;
        i_sig_ok <= 1'b0;
      end
      @(posedge i_clk_sys) i_sig_ok <= 1'b1;
      cyc(3);
      wait_st(i == 2 ? 2 : 1);
      if (i < 2) chk({o_link_up, o_spd_100, o_fdx, o_lp_an_able,
        o_lp_abil[7], o_lp_abil[5]}, i ? 6'h21 : 6'h32, "pd");
      else chk(o_pd_fault, 1'b1, "pd fault");
    end
    @(posedge i_clk_sys) {i_det_100, i_det_nlp, i_pdf_clr} <= 3'h1;
    @(posedge i_clk_sys) i_pdf_clr <= 1'b0;
    cyc(3);
    chk(o_pd_fault, 1'b0, "pd clear");
    // Forced modes with every carrier combination
    @(posedge i_clk_sys) {i_an_en_wr, i_an_en_val} <= 2'h2;
    @(posedge i_clk_sys) i_an_en_wr <= 1'b0;
    for (int m = 0; m < 16; m++) begin
      @(posedge i_clk_sys)
        {i_force_100, i_force_fdx, i_tx_en, i_rx_act} <= 4'(m);
      cyc(3);
      chk({o_an_en, o_spd_100, o_fdx}, 3'(m >> 2), "forced");
      chk({o_crs, o_col}, {m[2] ? m[0] : m[1] | m[0],
        !m[2] & m[1] & m[0]}, "carrier");
    end
    // Restart is refused while negotiation is off
    @(posedge i_clk_sys) {i_an_restart, i_tx_en, i_rx_act} <= 3'h4;
    @(posedge i_clk_sys) i_an_restart <= 1'b0;
    cyc(2);
    chk(o_traffic_off, 1'b0, "restart refused");
    // Jabber cut, release and sticky flag
    @(posedge i_clk_sys) i_tx_en <= 1'b1;
    cyc(JAB - 5);
    chk(o_tx_gate, 1'b1, "before cut");
    cyc(10);
    chk({o_tx_gate, o_jab_det}, 2'h1, "cut");
    @(posedge i_clk_sys) i_tx_en <= 1'b0;
    cyc(3);
    chk({o_tx_gate, o_jab_det}, 2'h3, "resume");
    @(posedge i_clk_sys) i_jab_clr <= 1'b1;
    @(posedge i_clk_sys) i_jab_clr <= 1'b0;
    cyc(3);
    chk(o_jab_det, 1'b0, "jab clear");
    final_report();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    err_total++;
    final_report();
  end
endmodule // autoneg_jabber_link_control_bench
